// *** design/bae_ctrl.sv ***
/*
  host-side sequencer for a byte-alterable 2048 x 8 memory on pins.
  assumes the memory is asynchronous and its pins settle within the stated times;
  pin inputs are synchronous to clock.
*/
`timescale 1ns/1ps
`default_nettype none
module bae_ctrl
  import bae_pkg::*;
#(
  parameter int PULSE_CYCLES = PULSE_CYC
) (
  input  wire logic                      clock,
  input  wire logic                      resetn,
  input  wire bae_pkg::bae_req_t         req,
  input  wire logic                      req_valid,
  output logic                           req_ready,
  output var  logic [bae_pkg::DATA_W-1:0] rd_data,
  output var  logic                      rd_valid,
  output var  logic [bae_pkg::ADDR_W-1:0] word_address_lines,
  output var  bae_pkg::bae_ctl_t         ctl,
  input  wire logic [bae_pkg::DATA_W-1:0] byte_data_lines_in,
  output var  logic [bae_pkg::DATA_W-1:0] byte_data_lines_out,
  output var  logic                      byte_data_lines_oe_n
);
  import bae_pkg::*;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {S_IDLE, S_SETUP, S_ACCESS, S_PULSE, S_HOLD} bae_state_t;

  bae_state_t         state_reg;
  bae_req_t           cur_reg;
  logic               tload;
  logic [CNT_W-1:0]   tcount;
  logic               tdone;
  logic               erase_phase_reg;

  bae_timer #(.W(CNT_W)) u_timer (
    .clock  (clock),
    .resetn (resetn),
    .load   (tload),
    .count  (tcount),
    .done   (tdone)
  );

  // only accept new work when every phase has closed out
  assign req_ready = (state_reg == S_IDLE);

  always_comb
  begin
    tload  = 1'b0;
    tcount = '0;
    case (state_reg)
      S_IDLE:
      begin
        if (req_valid)
        begin
          tload = 1'b1;
          tcount = (req.op == BAE_READ) ? CNT_W'(ACCESS_CYC) : CNT_W'(SETUP_CYC);
        end
      end
      S_SETUP:
      begin
        if (tdone)
        begin
          tload  = 1'b1;
          tcount = CNT_W'(PULSE_CYCLES);
        end
      end
      S_PULSE:
      begin
        if (tdone)
        begin
          tload  = 1'b1;
          tcount = CNT_W'(HOLD_CYC);
        end
      end
      S_HOLD:
      begin
        if (tdone && erase_phase_reg)
        begin
          tload  = 1'b1;
          tcount = CNT_W'(SETUP_CYC);
        end
      end
      default:
      begin
        tload  = 1'b0;
        tcount = '0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      state_reg <= S_IDLE;
    else
    begin
      case (state_reg)
        S_IDLE:   if (req_valid) state_reg <= (req.op == BAE_READ) ? S_ACCESS : S_SETUP;
        S_SETUP:  if (tdone) state_reg <= S_PULSE;
        S_ACCESS: if (tdone) state_reg <= S_IDLE;
        S_PULSE:  if (tdone) state_reg <= S_HOLD;
        S_HOLD:   if (tdone) state_reg <= erase_phase_reg ? S_SETUP : S_IDLE;
        default:  state_reg <= S_IDLE;
      endcase
    end
  end

  // request captured once and held unchanged for the whole operation
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      cur_reg <= '0;
    else if (state_reg == S_IDLE && req_valid)
    begin
      cur_reg <= req;
      if (req.op == BAE_ERASE)
        cur_reg.data <= ERASED_BYTE;
    end
  end

  // ---------------------------------------------------------------
  // erase before write
  // ---------------------------------------------------------------
  // every byte write opens with an erase pulse, so no write lands on an unerased word;
  // the cost is a second full pulse per write
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      erase_phase_reg <= 1'b0;
    else if (state_reg == S_IDLE && req_valid)
      erase_phase_reg <= (req.op == BAE_WRITE);
    else if (state_reg == S_HOLD && tdone)
      erase_phase_reg <= 1'b0;
  end

  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  // address moves on the take edge, a cycle ahead of select, to give it the full access time
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      word_address_lines <= '0;
    else if (state_reg == S_IDLE)
    begin
      if (req_valid)
        word_address_lines <= req.addr;
    end
    else
      word_address_lines <= cur_reg.addr;
  end

  // the erase phase of a write shows all ones before the new byte
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      byte_data_lines_out <= '0;
    else if (erase_phase_reg)
      byte_data_lines_out <= ERASED_BYTE;
    else
      byte_data_lines_out <= cur_reg.data;
  end

  // data lines are don't-care for array erase, so leave them floating
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      byte_data_lines_oe_n <= 1'b1;
    else
    begin
      case (state_reg)
        S_SETUP, S_PULSE, S_HOLD:
          byte_data_lines_oe_n <= (cur_reg.op == BAE_CHIP_ERASE);
        default:
          byte_data_lines_oe_n <= 1'b1;
      endcase
    end
  end

  // select stays low between the two pulses of a write so the word is never released
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      ctl <= CTL_IDLE;
    else
    begin
      case (state_reg)
        S_ACCESS:
          ctl <= '{select_n: 1'b0, gate_n: 1'b0, strobe: 1'b0};
        S_SETUP, S_PULSE, S_HOLD:
        begin
          ctl.select_n <= 1'b0;
          // array erase keeps the gate low; byte ops raise it
          ctl.gate_n   <= (cur_reg.op != BAE_CHIP_ERASE);
          // strobe drops on the edge at which the pulse count runs out
          ctl.strobe   <= (state_reg == S_PULSE) && !tdone;
        end
        default:
          ctl <= CTL_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // read return
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_data  <= '0;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_valid <= (state_reg == S_ACCESS) && tdone;
      if ((state_reg == S_ACCESS) && tdone)
        rd_data <= byte_data_lines_in;
    end
  end

endmodule : bae_ctrl
`default_nettype wire

// *** design/bae_pkg.sv ***
/*
  constants and carrier types for the byte-alterable memory controller.
  assumes a 10 MHz system clock and an external 2048 x 8 memory on pins.
*/
package bae_pkg;
  // ---------------------------------------------------------------
  // geometry and timing
  // ---------------------------------------------------------------
  localparam int ADDR_W       = 11;
  localparam int DATA_W       = 8;
  localparam int CLK_HZ       = 10_000_000;
  localparam int CLK_NS       = 1_000_000_000 / CLK_HZ;
  localparam int ACCESS_NS    = 300;
  localparam int ACCESS_CYC   = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_NS     = 200;
  localparam int SETUP_CYC    = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_US      = 2;
  localparam int HOLD_CYC     = (HOLD_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_MS     = 20;
  localparam int PULSE_CYC    = PULSE_MS * (CLK_HZ / 1000);
  localparam int CNT_W        = 24;
  localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {BAE_READ, BAE_ERASE, BAE_WRITE, BAE_CHIP_ERASE} bae_op_t;

  typedef struct packed {
    bae_op_t           op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } bae_req_t;

  typedef struct packed {
    logic select_n;
    logic gate_n;
    logic strobe;
  } bae_ctl_t;

  localparam bae_ctl_t CTL_IDLE = '{select_n: 1'b1, gate_n: 1'b1, strobe: 1'b0};
endpackage : bae_pkg

// *** design/bae_timer.sv ***
/*
  down-counter used to time setup, access, pulse and hold phases.
  assumes load is a single-cycle pulse from the sequencer.
*/
`timescale 1ns/1ps
`default_nettype none
module bae_timer #(
  parameter int W = 24
) (
  input  wire logic         clock,
  input  wire logic         resetn,
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output var  logic         done
);
  logic [W-1:0] cnt_reg;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      cnt_reg <= '0;
    else if (load)
      cnt_reg <= count;
    else if (cnt_reg != '0)
      cnt_reg <= cnt_reg - 1'b1;
  end

  // done ignores load: the sequencer decodes load from done, so gating it would close a loop
  assign done = (cnt_reg == '0);
endmodule : bae_timer
`default_nettype wire

// *** testbench/bae_ctrl_asserts.sv ***
/* pin sequencing checker for bae_ctrl.
   assumes it is bound into bae_ctrl and sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module bae_ctrl_asserts
  import bae_pkg::*;
#(
  parameter int PULSE_CYCLES = 10
) (
  input wire logic                       clock,
  input wire logic                       resetn,
  input wire bae_pkg::bae_req_t          req,
  input wire logic                       req_valid,
  input wire logic                       req_ready,
  input wire logic                       rd_valid,
  input wire logic [bae_pkg::ADDR_W-1:0] word_address_lines,
  input wire bae_pkg::bae_ctl_t          ctl,
  input wire logic [bae_pkg::DATA_W-1:0] byte_data_lines_out,
  input wire logic                       byte_data_lines_oe_n
);
  bae_req_t op_reg;
  int       hi_reg;
  logic     first_reg;
  always_ff @(posedge clock or negedge resetn)
    if (!resetn) op_reg <= '0;
    else if (req_valid && req_ready) op_reg <= req;
  always_ff @(posedge clock or negedge resetn)
    if (!resetn) hi_reg <= 0;
    else hi_reg <= ctl.strobe ? hi_reg + 1 : 0;
  // high until the first pulse of an operation has ended
  always_ff @(posedge clock or negedge resetn)
    if (!resetn) first_reg <= 1'b1;
    else if (req_valid && req_ready) first_reg <= 1'b1;
    else if (hi_reg != 0 && !ctl.strobe) first_reg <= 1'b0;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence rd_take_s;
    req_valid && req_ready && req.op == BAE_READ;
  endsequence
  sequence pulse_s(bae_op_t o, logic f);
    ctl.strobe && op_reg.op == o && first_reg == f;
  endsequence
  read_answer_a: assert property (rd_take_s |-> ##1 !rd_valid [*4] ##1 rd_valid)
    else $error("read answer not on fifth edge");
  read_pins_a: assert property (rd_take_s |-> ##2 (!ctl.select_n && !ctl.gate_n && !ctl.strobe
    && word_address_lines == op_reg.addr)) else $error("read pins wrong");
  desel_quiet_a: assert property (ctl.select_n |-> !ctl.strobe && byte_data_lines_oe_n)
    else $error("deselected pins active");
  erase_data_a: assert property (pulse_s(BAE_ERASE, 1'b1) |-> ctl.gate_n && !byte_data_lines_oe_n
    && byte_data_lines_out == ERASED_BYTE && word_address_lines == op_reg.addr) else $error("erase pins wrong");
  write_erase_a: assert property (pulse_s(BAE_WRITE, 1'b1) |-> ctl.gate_n && !byte_data_lines_oe_n
    && byte_data_lines_out == ERASED_BYTE && word_address_lines == op_reg.addr) else $error("write without erase");
  write_data_a: assert property (pulse_s(BAE_WRITE, 1'b0) |-> ctl.gate_n && !byte_data_lines_oe_n
    && byte_data_lines_out == op_reg.data && word_address_lines == op_reg.addr) else $error("write pins wrong");
  chip_erase_a: assert property (pulse_s(BAE_CHIP_ERASE, 1'b1) |-> !ctl.gate_n && byte_data_lines_oe_n)
    else $error("array erase pins wrong");
  pulse_len_a: assert property ($fell(ctl.strobe) |-> hi_reg == PULSE_CYCLES)
    else $error("pulse length wrong");
  pulse_hold_a: assert property (ctl.strobe |=> $stable(word_address_lines) && !ctl.select_n && !req_ready)
    else $error("pins moved in pulse");
endmodule : bae_ctrl_asserts
bind bae_ctrl bae_ctrl_asserts #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk (.clock, .resetn, .req, .req_valid,
  .req_ready, .rd_valid, .word_address_lines, .ctl, .byte_data_lines_out, .byte_data_lines_oe_n);
`default_nettype wire

// *** testbench/bae_ctrl_tb.sv ***
/* self-checking bench for bae_ctrl with a memory model.
   assumes a short pulse parameter to keep the run brief. */
`timescale 1ns/1ps
`default_nettype none
module bae_ctrl_tb;
  import bae_pkg::*;
  logic              clock = 1'b0;
  logic              resetn = 1'b0;
  bae_req_t          req = '0;
  logic              req_valid = 1'b0;
  logic              req_ready, rd_valid, byte_data_lines_oe_n;
  logic [DATA_W-1:0] rd_data, byte_data_lines_in, byte_data_lines_out;
  logic [ADDR_W-1:0] word_address_lines;
  bae_ctl_t          ctl;
  int                fail_count = 0;
  int                checks = 0;
  always #50 clock = ~clock;
  bae_ctrl #(.PULSE_CYCLES(10)) u_dut (.clock, .resetn, .req, .req_valid, .req_ready, .rd_data, .rd_valid,
    .word_address_lines, .ctl, .byte_data_lines_in, .byte_data_lines_out, .byte_data_lines_oe_n);
  bae_mem_model u_mem (.word_address_lines, .ctl, .host_data(byte_data_lines_out),
    .host_oe_n(byte_data_lines_oe_n), .data_lines(byte_data_lines_in));
  // --------
  // shared tasks
  // --------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic issue(input bae_op_t op, input logic [10:0] a, input logic [7:0] d);
    @(negedge clock);
    req = '{op: op, addr: a, data: d};
    req_valid = 1'b1;
    for (int n = 0; n < 200 && req_ready !== 1'b1; n++) @(negedge clock);
    checks++;
    if (req_ready !== 1'b1)
    begin
      fail_count++;
      $display("mismatch at %0t: request never taken", $time);
    end
    @(negedge clock);
    req_valid = 1'b0;
  endtask : issue
  task automatic read_chk(input logic [10:0] a, input logic [7:0] exp);
    issue(BAE_READ, a, 8'h00);
    for (int n = 0; n < 8 && rd_valid !== 1'b1; n++) @(negedge clock);
    chk({7'h00, rd_valid}, 8'h01);
    chk(rd_data, exp);
  endtask : read_chk
  task automatic finish_test();
    if (fail_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  // --------
  // scenarios
  // --------
  task automatic t_reads();
    chk({4'h0, byte_data_lines_oe_n, ctl}, {4'h0, 1'b1, CTL_IDLE});
    read_chk(11'h001, 8'h01);
    read_chk(11'h401, 8'h81);
    read_chk(11'h7FF, 8'h00);
  endtask : t_reads
  task automatic t_byte();
    issue(BAE_ERASE, 11'h401, 8'h00);
    read_chk(11'h401, 8'hFF);
    read_chk(11'h001, 8'h01);
    issue(BAE_WRITE, 11'h401, 8'h3C);
    read_chk(11'h401, 8'h3C);
    issue(BAE_WRITE, 11'h001, 8'h5A);
    read_chk(11'h001, 8'h5A);
  endtask : t_byte
  task automatic t_chip();
    issue(BAE_CHIP_ERASE, 11'h000, 8'h00);
    read_chk(11'h001, 8'hFF);
    read_chk(11'h7FF, 8'hFF);
  endtask : t_chip
  task automatic t_abort();
    issue(BAE_WRITE, 11'h002, 8'h00);
    repeat (5) @(negedge clock);
    resetn = 1'b0;
    @(negedge clock);
    chk({4'h0, byte_data_lines_oe_n, ctl}, {4'h0, 1'b1, CTL_IDLE});
    resetn = 1'b1;
    read_chk(11'h7FF, 8'hFF);
  endtask : t_abort
  initial
  begin
    repeat (16) @(negedge clock);
    resetn = 1'b1;
    t_reads();
    t_byte();
    t_chip();
    t_abort();
    finish_test();
  end
  initial
  begin
    repeat (5000) @(posedge clock);
    fail_count++;
    finish_test();
  end
endmodule : bae_ctrl_tb
`default_nettype wire

// *** testbench/bae_mem_model.sv ***
/* behavioural 2048 x 8 byte-alterable memory on pins.
   assumes pins come from bae_ctrl; resolves the shared data wire. */
`timescale 1ns/1ps
`default_nettype none
module bae_mem_model
  import bae_pkg::*;
(
  input  wire logic [bae_pkg::ADDR_W-1:0] word_address_lines,
  input  wire bae_pkg::bae_ctl_t          ctl,
  input  wire logic [bae_pkg::DATA_W-1:0] host_data,
  input  wire logic                       host_oe_n,
  output var  logic [bae_pkg::DATA_W-1:0] data_lines
);
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [ADDR_W-1:0] settled;
  logic [DATA_W-1:0] q;
  // data only valid once the address has stood for the access time
  assign #299 settled = word_address_lines;
  assign q = mem[word_address_lines];
  initial for (int i = 0; i < 2**ADDR_W; i++) mem[i] = DATA_W'(i ^ (i >> 3));
  // released wire shows the inverse so a stale sample cannot match
  always_comb
    if (!host_oe_n) data_lines = host_data;
    else if (!ctl.select_n && !ctl.gate_n && !ctl.strobe && settled == word_address_lines) data_lines = q;
    else data_lines = ~q;
  // commit at pulse end; an unerased write only clears bits
  always @(negedge ctl.strobe)
    if (ctl.select_n) ;
    else if (!ctl.gate_n) for (int i = 0; i < 2**ADDR_W; i++) mem[i] = ERASED_BYTE;
    else if (host_data == ERASED_BYTE) mem[word_address_lines] = ERASED_BYTE;
    else mem[word_address_lines] = mem[word_address_lines] & host_data;
endmodule : bae_mem_model
`default_nettype wire
